/* scrt_pkg.sv */
// Constants shared by the slow-clock real-time timer.
// Assumes a 32-bit AHB-Lite register bus and a slow clock sampled on CLK.
// Notes on behaviour
// [RULE_01] Slow clock is divided by a 16-bit prescaler set by prescale_value.
// [RULE_02] prescale_value resets to 0x8000: one roll a second at 32.768 kHz.
// [RULE_03] The 32-bit counter counts up and wraps to zero after its maximum.
// [RULE_04] Every prescaler roll-over sets tick_flag.
// [RULE_05] With seconds_source_select at 1, the 1 Hz input steps the counter.
// [RULE_06] With seconds_source_select at 0, each roll-over steps the counter.
// [RULE_07] tick_flag follows roll-overs whichever source drives the counter.
// [RULE_08] Software never programs prescale_value to 1 or 2; 3 is finest.
// [RULE_09] A status-read clear lands two slow clock cycles after the read.
// [RULE_10] Handler disables the timer interrupt until the flags are cleared.
// [RULE_11] counter_value reads anytime; software rereads until two agree.
// [RULE_12] alarm_flag is set while the counter equals alarm_value.
// [RULE_13] alarm_value resets to its maximum so no early match occurs.
// [RULE_14] Alarm wake-up output follows alarm_flag regardless of enables.
// [RULE_15] Software clears alarm_irq_enable before writing a new alarm_value.
// [RULE_16] Software clears tick_irq_enable before a new prescale_value.
// [RULE_17] Reading the status register clears tick_flag and alarm_flag.
// [RULE_18] restart_request reloads the prescaler and zeroes the counter.
// [RULE_19] timer_disable stops prescaler and counter activity.
// [RULE_20] At reset settings tick_flag gives a one-second periodic event.
// [RULE_21] Interrupt is asserted for an enabled tick_flag or alarm_flag.
// [RULE_22] Counting runs on slow clock steps; bus accesses are taken in.
package scrt_pkg;
  localparam int SCRT_DATA_W = 32;
  localparam int SCRT_ADDR_W = 32;
  // Register byte offsets
  localparam logic [7:0] SCRT_MODE_OFS = 8'h00;
  localparam logic [7:0] SCRT_ALARM_OFS = 8'h04;
  localparam logic [7:0] SCRT_VALUE_OFS = 8'h08;
  localparam logic [7:0] SCRT_STATUS_OFS = 8'h0C;
  localparam int SCRT_DEC_W = 8;
  // Mode register fields
  localparam int SCRT_PRES_LSB = 0;
  localparam int SCRT_ALMIE_BIT = 16;
  localparam int SCRT_TICKIE_BIT = 17;
  localparam int SCRT_RESTART_BIT = 18;
  localparam int SCRT_DIS_BIT = 20;
  localparam int SCRT_SRC_BIT = 24;
  // Status register fields
  localparam int SCRT_ALMF_BIT = 0;
  localparam int SCRT_TICKF_BIT = 1;
  // Reset values
  localparam logic [15:0] SCRT_PRES_RST = 16'h8000;
  localparam logic [31:0] SCRT_ALARM_RST = 32'hFFFF_FFFF;
  // Slow clock steps between a status read and its clear
  localparam int SCRT_CLR_STEPS = 2;
  // AHB encodings
  localparam logic [1:0] SCRT_HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic SCRT_HRESP_OKAY = 1'b0;
endpackage

/* scrt_edge_det.sv */
// Rising-edge detector for a level already synchronous to the clock.
// Assumes the level is sampled on every enabled clock edge.
`timescale 1ns/1ps
module scrt_edge_det (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic level,
  output logic rise
);
  logic level_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= 1'b0;
    end else if (ce) begin
      level_r <= level;
    end
  end

  assign rise = ce & level & ~level_r;
endmodule

/* scrt_prescaler.sv */
// Programmable divider: pulses roll once every div_value steps.
// Assumes a div_value of zero means the full range, 2**W steps.
`timescale 1ns/1ps
module scrt_prescaler #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic step,
  input wire logic reload,
  input wire logic [W-1:0] div_value,
  output logic roll
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_inc;

  generate
    if (W < 2) begin : g_bad_width
      $error("scrt_prescaler needs at least two bits");
    end
  endgenerate

  assign cnt_inc = cnt_r + {{(W-1){1'b0}}, 1'b1};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      roll <= 1'b0;
    end else if (ce) begin
      roll <= 1'b0;
      if (reload) begin
        cnt_r <= '0; // see [RULE_18]
      end else if (step) begin
        if (cnt_inc == div_value) begin
          cnt_r <= '0;
          roll <= 1'b1; // see [RULE_01]
        end else begin
          cnt_r <= cnt_inc;
        end
      end
    end
  end
endmodule

/* scrt_timer_top.sv */
// Slow-clock real-time timer with an AHB-Lite register slave.
// Assumes SLOW_CLK and ONE_HZ are levels synchronous to CLK, and CLK is
// much faster than either, so every slow edge is seen.
`timescale 1ns/1ps
module scrt_timer_top
  import scrt_pkg::*;
#(
  parameter int PRES_W = 16,
  parameter int CNT_W = 32
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [SCRT_ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [SCRT_DATA_W-1:0] HWDATA,
  input wire logic HREADY,
  output logic [SCRT_DATA_W-1:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SLOW_CLK,
  input wire logic ONE_HZ,
  output logic IRQ,
  output logic ALARM_WAKE
);
  generate
    if (PRES_W != 16 || CNT_W != 32) begin : g_bad_size
      $error("scrt_timer_top supports a 16-bit prescaler, 32-bit counter");
    end
  endgenerate

  // Reset release through two flip-flops
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Slow clock steps and 1 Hz steps
  logic slow_step;
  logic one_hz_step;

  scrt_edge_det u_slow_edge (
    .clk(CLK),
    .rst_n(rst_sync_r),
    .ce(CE),
    .level(SLOW_CLK),
    .rise(slow_step)
  );

  scrt_edge_det u_one_hz_edge (
    .clk(CLK),
    .rst_n(rst_sync_r),
    .ce(CE),
    .level(ONE_HZ),
    .rise(one_hz_step)
  );

  // Software-visible settings
  logic [PRES_W-1:0] prescale_value_r;
  logic alarm_irq_enable_r;
  logic tick_irq_enable_r;
  logic timer_disable_r;
  logic seconds_source_select_r;
  logic [CNT_W-1:0] alarm_value_r;
  logic restart_pend_r;

  // Timer state
  logic [CNT_W-1:0] counter_value_r;
  logic tick_flag_r;
  logic alarm_flag_r;
  logic [SCRT_CLR_STEPS-1:0] clr_stage_r;
  logic pres_roll;
  logic run_step;
  logic restart_now;

  // Bus data-phase state
  logic dphase_r;
  logic dphase_write_r;
  logic [SCRT_DEC_W-1:0] dphase_addr_r;
  logic addr_take;
  logic wr_mode;
  logic wr_alarm;
  logic rd_status;
  logic [SCRT_DATA_W-1:0] rd_data;
  logic [SCRT_DATA_W-1:0] mode_word;
  logic [SCRT_DATA_W-1:0] status_word;

  assign addr_take = HSEL & HREADY & HTRANS[1] & ~dphase_r;
  assign wr_mode = dphase_r & dphase_write_r
    & (dphase_addr_r == SCRT_MODE_OFS);
  assign wr_alarm = dphase_r & dphase_write_r
    & (dphase_addr_r == SCRT_ALARM_OFS);
  assign rd_status = dphase_r & ~dphase_write_r
    & (dphase_addr_r == SCRT_STATUS_OFS);

  // Address phase is latched, then one wait cycle before the answer
  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      dphase_r <= 1'b0;
      dphase_write_r <= 1'b0;
      dphase_addr_r <= '0;
      HREADYOUT <= 1'b1;
    end else if (CE) begin
      if (addr_take) begin
        dphase_r <= 1'b1;
        dphase_write_r <= HWRITE;
        dphase_addr_r <= HADDR[SCRT_DEC_W-1:0];
        HREADYOUT <= 1'b0;
      end else if (dphase_r) begin
        dphase_r <= 1'b0;
        HREADYOUT <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      HRESP <= SCRT_HRESP_OKAY;
    end else if (CE) begin
      HRESP <= SCRT_HRESP_OKAY;
    end
  end

  always_comb begin
    mode_word = '0;
    mode_word[SCRT_PRES_LSB +: PRES_W] = prescale_value_r;
    mode_word[SCRT_ALMIE_BIT] = alarm_irq_enable_r;
    mode_word[SCRT_TICKIE_BIT] = tick_irq_enable_r;
    mode_word[SCRT_DIS_BIT] = timer_disable_r;
    mode_word[SCRT_SRC_BIT] = seconds_source_select_r;
  end

  always_comb begin
    status_word = '0;
    status_word[SCRT_ALMF_BIT] = alarm_flag_r;
    status_word[SCRT_TICKF_BIT] = tick_flag_r;
  end

  // Unmapped offsets read as zero
  always_comb begin
    unique case (dphase_addr_r)
      SCRT_MODE_OFS: rd_data = mode_word;
      SCRT_ALARM_OFS: rd_data = alarm_value_r;
      SCRT_VALUE_OFS: rd_data = counter_value_r; // see [RULE_11]
      SCRT_STATUS_OFS: rd_data = status_word;
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      HRDATA <= '0;
    end else if (CE) begin
      if (dphase_r && !dphase_write_r) begin
        HRDATA <= rd_data;
      end
    end
  end

  // Mode register; restart is a write-only strobe
  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      prescale_value_r <= SCRT_PRES_RST; // see [RULE_02]
      alarm_irq_enable_r <= 1'b0;
      tick_irq_enable_r <= 1'b0;
      timer_disable_r <= 1'b0;
      seconds_source_select_r <= 1'b0;
    end else if (CE) begin
      if (wr_mode) begin
        prescale_value_r <= HWDATA[SCRT_PRES_LSB +: PRES_W];
        alarm_irq_enable_r <= HWDATA[SCRT_ALMIE_BIT];
        tick_irq_enable_r <= HWDATA[SCRT_TICKIE_BIT];
        timer_disable_r <= HWDATA[SCRT_DIS_BIT];
        seconds_source_select_r <= HWDATA[SCRT_SRC_BIT];
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      alarm_value_r <= SCRT_ALARM_RST; // see [RULE_13]
    end else if (CE) begin
      if (wr_alarm) begin
        alarm_value_r <= HWDATA;
      end
    end
  end

  // Restart waits for the next slow step, then acts at once
  assign restart_now = restart_pend_r & slow_step;

  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      restart_pend_r <= 1'b0;
    end else if (CE) begin
      if (wr_mode && HWDATA[SCRT_RESTART_BIT]) begin
        restart_pend_r <= 1'b1; // see [RULE_22]
      end else if (restart_now) begin
        restart_pend_r <= 1'b0;
      end
    end
  end

  // Disabled timer takes no steps at all
  assign run_step = slow_step & ~timer_disable_r; // see [RULE_19]

  scrt_prescaler #(
    .W(PRES_W)
  ) u_prescaler (
    .clk(CLK),
    .rst_n(rst_sync_r),
    .ce(CE),
    .step(run_step),
    .reload(restart_now), // see [RULE_18]
    .div_value(prescale_value_r),
    .roll(pres_roll)
  );

  // Seconds counter
  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      counter_value_r <= '0;
    end else if (CE) begin
      if (restart_now) begin
        counter_value_r <= '0; // see [RULE_18]
      end else if (!timer_disable_r) begin
        if (seconds_source_select_r ? one_hz_step : pres_roll) begin
          // Natural wrap at the top of the range, see [RULE_03]
          counter_value_r <= counter_value_r + 32'h0000_0001; // see [RULE_05]
        end // see [RULE_06]
      end
    end
  end

  // Status read clear travels two slow steps before it lands
  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      clr_stage_r <= '0;
    end else if (CE) begin
      if (slow_step) begin
        clr_stage_r <= {clr_stage_r[SCRT_CLR_STEPS-2:0], rd_status};
      end else if (rd_status) begin
        clr_stage_r[0] <= 1'b1; // see [RULE_09]
      end
    end
  end

  logic flag_clear;
  assign flag_clear = slow_step & clr_stage_r[SCRT_CLR_STEPS-1];

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      tick_flag_r <= 1'b0;
    end else if (CE) begin
      if (pres_roll) begin
        tick_flag_r <= 1'b1; // see [RULE_04] see [RULE_07] see [RULE_20]
      end else if (flag_clear) begin
        tick_flag_r <= 1'b0; // see [RULE_17]
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      alarm_flag_r <= 1'b0;
    end else if (CE) begin
      if (counter_value_r == alarm_value_r) begin
        alarm_flag_r <= 1'b1; // see [RULE_12]
      end else if (flag_clear) begin
        alarm_flag_r <= 1'b0; // see [RULE_17]
      end
    end
  end

  // Outputs follow the flags one cycle later
  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      IRQ <= 1'b0;
      ALARM_WAKE <= 1'b0;
    end else if (CE) begin
      IRQ <= (tick_flag_r & tick_irq_enable_r)
        | (alarm_flag_r & alarm_irq_enable_r); // see [RULE_21]
      ALARM_WAKE <= alarm_flag_r; // see [RULE_14]
    end
  end
endmodule

/* scrt_timer_properties.sv */
// Checker for bus timing and output causes of the slow-clock timer.
// Assumes one clock domain and HREADY tied to HREADYOUT.
`timescale 1ns/1ps
module scrt_timer_properties
  import scrt_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [SCRT_DATA_W-1:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SLOW_CLK,
  input wire logic ONE_HZ,
  input wire logic IRQ,
  input wire logic ALARM_WAKE
);
  logic take;
  logic slow_d;
  logic hz_d;
  logic [3:0] since_sl;
  logic [3:0] since_ev;
  assign take = CE && HSEL && HREADY && HTRANS[1];
  // Cycles since the last slow step, and since any event that may move
  // a flag or an enable
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      slow_d <= 1'b0;
      hz_d <= 1'b0;
      since_sl <= 4'hF;
      since_ev <= 4'hF;
    end else begin
      slow_d <= SLOW_CLK;
      hz_d <= ONE_HZ;
      if (SLOW_CLK && !slow_d) since_sl <= 4'h0;
      else if (since_sl != 4'hF) since_sl <= since_sl + 4'h1;
      if ((SLOW_CLK && !slow_d) || (ONE_HZ && !hz_d) || (take && HWRITE))
        since_ev <= 4'h0;
      else if (since_ev != 4'hF) since_ev <= since_ev + 4'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  okay_resp_a: assert property (HRESP == SCRT_HRESP_OKAY)
    else $error("bus response not OKAY");
  wait_state_a: assert property (
    take |=> !HREADYOUT ##1 HREADYOUT)
    else $error("data phase not one wait state");
  ready_cause_a: assert property (
    $fell(HREADYOUT) |-> $past(take))
    else $error("wait state without a transfer");
  rdata_hold_a: assert property (
    $changed(HRDATA) |-> $past(take && !HWRITE, 2))
    else $error("read data moved outside a read");
  reset_quiet_a: assert property (
    $rose(RST_B) |-> (HREADYOUT && !IRQ && !ALARM_WAKE)[*2])
    else $error("outputs active right after reset");
  irq_cause_a: assert property (
    $rose(IRQ) |-> since_ev <= 4'h6)
    else $error("interrupt rose with no cause");
  wake_cause_a: assert property (
    $rose(ALARM_WAKE) |-> since_ev <= 4'h6)
    else $error("wake rose with no cause");
  wake_clear_a: assert property (
    $fell(ALARM_WAKE) |-> since_sl <= 4'h6)
    else $error("wake cleared away from a slow step");
  irq_fall_a: assert property (
    $fell(IRQ) |-> since_ev <= 4'h6)
    else $error("interrupt fell with no cause");
  ce_freeze_a: assert property (
    !CE |=> $stable(IRQ) && $stable(ALARM_WAKE) && $stable(HREADYOUT))
    else $error("outputs moved while the clock enable was low");
  cover property ($rose(IRQ));
  cover property ($fell(ALARM_WAKE));
  cover property (take && !HWRITE);
endmodule

bind scrt_timer_top scrt_timer_properties chk (.CLK(CLK), .RST_B(RST_B),
  .CE(CE), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .SLOW_CLK(SLOW_CLK), .ONE_HZ(ONE_HZ), .IRQ(IRQ),
  .ALARM_WAKE(ALARM_WAKE));

/* scrt_timer_bench.sv */
// Self-checking bench for the slow-clock timer over its register bus.
// Assumes slow steps and 1 Hz pulses are levels driven from CLK.
`timescale 1ns/1ps
module scrt_timer_bench
  import scrt_pkg::*;
;
  localparam logic [31:0] b_aie = 32'h1 << SCRT_ALMIE_BIT;
  localparam logic [31:0] b_tie = 32'h1 << SCRT_TICKIE_BIT;
  localparam logic [31:0] b_rst = 32'h1 << SCRT_RESTART_BIT;
  localparam logic [31:0] b_dis = 32'h1 << SCRT_DIS_BIT;
  localparam logic [31:0] b_src = 32'h1 << SCRT_SRC_BIT;
  logic clk, rst_b, hsel, hwrite, slow, hz, hreadyout, hresp, irq, wake;
  logic ce;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic ph = 1'b0;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  scrt_timer_top uut (.CLK(clk), .RST_B(rst_b), .CE(ce), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .SLOW_CLK(slow), .ONE_HZ(hz),
    .IRQ(irq), .ALARM_WAKE(wake));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One single transfer; a read notes its expected data
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= SCRT_HTRANS_NONSEQ_BIT;
    haddr <= {24'h0, a};
    hwrite <= w;
    if (!w) exp_q.push_back(d);
    do @(posedge clk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk); while (!hreadyout);
  endtask
  // n slow steps, or n 1 Hz pulses
  task automatic pace(input int n, input bit one_hz);
    repeat (n) begin
      @(posedge clk);
      if (one_hz) hz <= 1'b1;
      else slow <= 1'b1;
      repeat (4) @(posedge clk);
      hz <= 1'b0;
      slow <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // Read data is taken where the data phase ends
  always @(posedge clk) begin
    if (ph && hreadyout) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, {31'h0, SCRT_HRESP_OKAY});
    end
    if (hsel && htrans[1] && !hwrite && hreadyout) ph <= 1'b1;
    else if (hreadyout) ph <= 1'b0;
  end
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    slow = 1'b0;
    hz = 1'b0;
    void'($urandom(32'hcd3a8779));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(0, SCRT_MODE_OFS, {16'h0, SCRT_PRES_RST});
    xfer(0, SCRT_ALARM_OFS, SCRT_ALARM_RST);
    xfer(0, SCRT_VALUE_OFS, 32'h0);
    xfer(0, SCRT_STATUS_OFS, 32'h0);
    xfer(1, SCRT_VALUE_OFS, 32'h5);
    xfer(0, SCRT_VALUE_OFS, 32'h0);
    xfer(0, 8'h10, 32'h0);
    r = $urandom() | 32'h8000_0000;
    xfer(1, SCRT_ALARM_OFS, r);
    xfer(0, SCRT_ALARM_OFS, r);
    xfer(1, SCRT_ALARM_OFS, 32'h2);
    xfer(1, SCRT_MODE_OFS, b_tie | b_rst | 32'h3);
    xfer(0, SCRT_MODE_OFS, b_tie | 32'h3);
    pace(4, 0);
    xfer(0, SCRT_VALUE_OFS, 32'h1);
    chk({30'h0, irq, wake}, 32'h2);
    xfer(0, SCRT_STATUS_OFS, 32'h2);
    pace(1, 0);
    chk({30'h0, irq, wake}, 32'h2);
    pace(1, 0);
    chk({30'h0, irq, wake}, 32'h0);
    pace(1, 0);
    chk({30'h0, irq, wake}, 32'h3);
    xfer(1, SCRT_MODE_OFS, 32'h3);
    xfer(0, SCRT_STATUS_OFS, 32'h3);
    chk({30'h0, irq, wake}, 32'h1);
    xfer(1, SCRT_ALARM_OFS, SCRT_ALARM_RST);
    pace(2, 0);
    chk({30'h0, irq, wake}, 32'h0);
    pace(1, 0);
    xfer(0, SCRT_STATUS_OFS, 32'h2);
    pace(1, 1);
    xfer(0, SCRT_VALUE_OFS, 32'h3);
    xfer(1, SCRT_MODE_OFS, b_src | 32'h3);
    pace(1, 1);
    pace(3, 0);
    xfer(0, SCRT_VALUE_OFS, 32'h4);
    xfer(0, SCRT_STATUS_OFS, 32'h2);
    xfer(1, SCRT_MODE_OFS, b_dis | 32'h3);
    pace(3, 0);
    pace(1, 1);
    xfer(0, SCRT_VALUE_OFS, 32'h4);
    xfer(1, SCRT_ALARM_OFS, 32'h1);
    xfer(1, SCRT_MODE_OFS, b_aie | b_rst | 32'h3);
    pace(1, 0);
    xfer(0, SCRT_VALUE_OFS, 32'h0);
    pace(3, 0);
    chk({30'h0, irq, wake}, 32'h3);
    xfer(0, SCRT_VALUE_OFS, 32'h1);
    // Slow steps with the clock enable low must leave every count alone
    ce <= 1'b0;
    pace(3, 0);
    ce <= 1'b1;
    xfer(0, SCRT_VALUE_OFS, 32'h1);
    xfer(0, SCRT_STATUS_OFS, 32'h3);
    // Let the last read be compared before the queue is checked empty
    repeat (2) @(posedge clk);
    chk(32'(exp_q.size()), 32'h0);
    stop_test();
  end
endmodule
